/* rtl/tpfg_pkg.sv */
// constants, register map and types of the transmit pause frame generator
package tpfg_pkg;

	localparam int          NCLS        = 9;
	localparam int          GLOBAL_IDX  = 8;
	localparam int          HDR_WORDS   = 5;

	// register byte addresses
	localparam logic [11:0] ADR_CTRL    = 12'h000;
	localparam logic [11:0] ADR_STATUS  = 12'h004;
	localparam logic [11:0] ADR_MASK    = 12'h008;
	localparam logic [11:0] ADR_STATE   = 12'h00c;
	localparam logic [11:0] ADR_QUANTA  = 12'h040;
	localparam logic [11:0] ADR_REFRESH = 12'h080;
	localparam logic [11:0] ADR_HDR     = 12'h0c0;

	// field positions
	localparam int          CTRL_RESEND_BIT = 16;
	localparam int          STATE_BUSY_BIT  = 16;

	// reset values
	localparam logic [47:0] RST_DA        = 48'h0180c2000001;
	localparam logic [47:0] RST_SA        = 48'h000000000000;
	localparam logic [15:0] RST_ETYPE     = 16'h8808;
	localparam logic [15:0] RST_OPCODE_GP = 16'h0001;
	localparam logic [15:0] RST_OPCODE_PP = 16'h0101;
	localparam logic [15:0] RST_QUANTA    = 16'hffff;
	localparam logic [15:0] RST_REFRESH   = 16'h0000;
	localparam logic [8:0]  RST_MASK      = 9'h000;

	// frame layout, byte indices
	localparam logic [5:0]  FCS_IDX  = 6'h3c;
	localparam logic [5:0]  LAST_IDX = 6'h3f;

	// crc-32, reflected
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;

	// one pause quantum is 512 bit times at 40 Gb/s
	localparam int          CLK_PERIOD_PS = 10000;
	localparam int          QUANTUM_PS    = 12800;
	localparam int          TICK_CYCLES   = (QUANTUM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0]  TICK_LAST     = 4'(TICK_CYCLES - 1);

	typedef enum logic [0:0] {
		TPFG_IDLE = 1'b0,
		TPFG_SEND = 1'b1
	} tpfg_state_t;

endpackage

/* rtl/tpfg_crc32.sv */
// byte-wide ethernet crc-32 accumulator
`timescale 1ns/1ps
module tpfg_crc32 (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        init,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	output logic      [31:0] nxt_crc
);

	logic [31:0] crc_ff;

	always_comb begin
		logic [31:0] c;
		c = crc_ff;
		for (int i = 0; i < 8; i++) begin
			c = ((c[0] ^ data[i]) != 1'b0) ? ((c >> 1) ^ tpfg_pkg::CRC_POLY) : (c >> 1);
		end
		nxt_crc = c;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crc_ff <= tpfg_pkg::CRC_INIT;
		end else if (init) begin
			crc_ff <= tpfg_pkg::CRC_INIT;
		end else if (en) begin
			crc_ff <= nxt_crc;
		end
	end

endmodule

/* rtl/tpfg_class_timer.sv */
// per-class pause request tracker and refresh timer
`timescale 1ns/1ps
module tpfg_class_timer (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        tick,
	input  wire logic        req,
	input  wire logic        take,
	input  wire logic        resend,
	input  wire logic [15:0] refresh,
	output logic             due
);

	logic        req_d_ff;
	logic        pend_ff;
	logic [15:0] cnt_ff;
	logic        expire;
	logic        set_p;

	assign expire = tick & req & (cnt_ff == 16'h0001);
	assign set_p  = (req & ~req_d_ff) | expire | (resend & req);
	assign due    = pend_ff & req;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_d_ff <= 1'b0;
		end else begin
			req_d_ff <= req;
		end
	end

	// set wins over the clear of a frame start
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff <= 1'b0;
		end else if (set_p) begin
			pend_ff <= 1'b1;
		end else if (take || !req) begin
			pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 16'h0000;
		end else if (take || resend) begin
			cnt_ff <= refresh;
		end else if (tick && cnt_ff != 16'h0000) begin
			cnt_ff <= cnt_ff - 16'h0001;
		end
	end

endmodule

/* rtl/tpfg_top.sv */
// transmit pause frame generator with wishbone register access
// Overview of operation
// - any set request bit sends a pause frame with that class's quanta.
// - bit 8 sends a global frame; bits 0 to 7 a priority frame.
// - nine 16-bit quanta; entry 8 global, entries 0 to 7 priorities.
// - nine 16-bit refresh timers set each class's retransmission interval.
// - global frames use their own address, ethertype and opcode settings.
// - priority frames use a separate address, ethertype and opcode set.
// - resend retransmits frames for all requested classes after the frame in flight.
// - a taken resend also reloads every per-class retransmission counter.
// - each sent frame pulses the bits of all its classes on the sent status output.
`timescale 1ns/1ps
module tpfg_top (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [11:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        LINK_BUSY,
	input  wire logic        TX_READY,
	output logic             TX_VALID,
	output logic      [7:0]  TX_DATA,
	output logic             TX_SOF,
	output logic             TX_EOF,
	output logic      [8:0]  TX_PAUSE_VALID,
	output logic             IRQ
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic        [8:0]  req_ff;
	logic               resend_ff;
	logic        [8:0]  status_ff;
	logic        [8:0]  mask_ff;
	logic        [15:0] quanta_ff  [tpfg_pkg::NCLS];
	logic        [15:0] refresh_ff [tpfg_pkg::NCLS];
	logic        [31:0] hdr_ff     [2 * tpfg_pkg::HDR_WORDS];
	logic               ack_ff;
	logic        [31:0] dat_ff;

	tpfg_pkg::tpfg_state_t state_ff;
	logic        [5:0]  idx_ff;
	logic               glob_ff;
	logic        [7:0]  vec_ff;
	logic        [7:0]  byte_ff;
	logic               sof_ff;
	logic               eof_ff;
	logic        [31:0] fcs_ff;
	logic        [8:0]  sent_ff;
	logic        [3:0]  tick_cnt_ff;
	logic               tick_ff;

	logic               wb_req;
	logic               wr;
	logic        [9:0]  wadr;
	logic        [8:0]  due;
	logic               start;
	logic               beat;
	logic               sel_glob;
	logic        [7:0]  sel_vec;
	logic        [8:0]  take;
	logic        [31:0] nxt_crc;
	logic        [5:0]  nxt_idx;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] frame_byte(input logic [5:0] idx, input logic glob,
			input logic [7:0] vec);
		logic [47:0] da;
		logic [47:0] sa;
		logic [31:0] eo;
		logic [7:0]  r;
		int          b;
		int          n;
		int          p;
		b  = glob ? 0 : tpfg_pkg::HDR_WORDS;
		da = {hdr_ff[b + 1][15:0], hdr_ff[b]};
		sa = {hdr_ff[b + 3][15:0], hdr_ff[b + 2]};
		eo = hdr_ff[b + 4];
		n  = int'(idx);
		r  = 8'h00;
		if (n < 6) begin
			r = 8'(da >> (8 * (5 - n)));
		end else if (n < 12) begin
			r = 8'(sa >> (8 * (11 - n)));
		end else if (n < 16) begin
			r = 8'(eo >> (8 * (15 - n)));
		end else if (glob) begin
			if (n < 18) begin
				r = 8'(quanta_ff[tpfg_pkg::GLOBAL_IDX] >> (8 * (17 - n)));
			end
		end else if (n == 17) begin
			r = vec;
		end else if (n >= 18 && n < 34) begin
			p = (n - 18) / 2;
			if (vec[p]) begin
				r = 8'(quanta_ff[p] >> (8 * (1 - ((n - 18) % 2))));
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, writes at the ack edge

	assign wb_req   = WB_CYC_I & WB_STB_I;
	assign wr       = ack_ff & wb_req & WB_WE_I;
	assign wadr     = WB_ADR_I[11:2];
	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = dat_ff;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_req & ~ack_ff;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dat_ff <= 32'h00000000;
		end else if (wb_req && !ack_ff) begin
			dat_ff <= 32'h00000000;
			for (int i = 0; i < tpfg_pkg::NCLS; i++) begin
				if (wadr == 10'((tpfg_pkg::ADR_QUANTA >> 2) + i)) begin
					dat_ff <= {16'h0000, quanta_ff[i]};
				end
				if (wadr == 10'((tpfg_pkg::ADR_REFRESH >> 2) + i)) begin
					dat_ff <= {16'h0000, refresh_ff[i]};
				end
			end
			for (int k = 0; k < 2 * tpfg_pkg::HDR_WORDS; k++) begin
				if (wadr == 10'((tpfg_pkg::ADR_HDR >> 2) + k)) begin
					dat_ff <= hdr_ff[k];
				end
			end
			if (wadr == tpfg_pkg::ADR_CTRL[11:2]) begin
				dat_ff <= {23'h000000, req_ff};
			end
			if (wadr == tpfg_pkg::ADR_STATUS[11:2]) begin
				dat_ff <= {23'h000000, status_ff};
			end
			if (wadr == tpfg_pkg::ADR_MASK[11:2]) begin
				dat_ff <= {23'h000000, mask_ff};
			end
			if (wadr == tpfg_pkg::ADR_STATE[11:2]) begin
				dat_ff <= {15'h0000, state_ff == tpfg_pkg::TPFG_SEND, 7'h00, due};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control, mask and configuration registers

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			req_ff    <= 9'h000;
			resend_ff <= 1'b0;
		end else begin
			resend_ff <= 1'b0;
			if (wr && wadr == tpfg_pkg::ADR_CTRL[11:2]) begin
				req_ff    <= 9'(merge({23'h000000, req_ff}, WB_DAT_I, WB_SEL_I));
				resend_ff <= WB_SEL_I[2] & WB_DAT_I[tpfg_pkg::CTRL_RESEND_BIT];
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mask_ff <= tpfg_pkg::RST_MASK;
		end else if (wr && wadr == tpfg_pkg::ADR_MASK[11:2]) begin
			mask_ff <= 9'(merge({23'h000000, mask_ff}, WB_DAT_I, WB_SEL_I));
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < tpfg_pkg::NCLS; i++) begin
				quanta_ff[i]  <= tpfg_pkg::RST_QUANTA;
				refresh_ff[i] <= tpfg_pkg::RST_REFRESH;
			end
		end else if (wr) begin
			for (int i = 0; i < tpfg_pkg::NCLS; i++) begin
				if (wadr == 10'((tpfg_pkg::ADR_QUANTA >> 2) + i)) begin
					quanta_ff[i] <= 16'(merge({16'h0000, quanta_ff[i]}, WB_DAT_I, WB_SEL_I));
				end
				if (wadr == 10'((tpfg_pkg::ADR_REFRESH >> 2) + i)) begin
					refresh_ff[i] <= 16'(merge({16'h0000, refresh_ff[i]}, WB_DAT_I, WB_SEL_I));
				end
			end
		end
	end

	// per set: da low, da high, sa low, sa high, {ethertype, opcode}
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int s = 0; s < 2; s++) begin
				hdr_ff[s * tpfg_pkg::HDR_WORDS]     <= tpfg_pkg::RST_DA[31:0];
				hdr_ff[s * tpfg_pkg::HDR_WORDS + 1] <= {16'h0000, tpfg_pkg::RST_DA[47:32]};
				hdr_ff[s * tpfg_pkg::HDR_WORDS + 2] <= tpfg_pkg::RST_SA[31:0];
				hdr_ff[s * tpfg_pkg::HDR_WORDS + 3] <= {16'h0000, tpfg_pkg::RST_SA[47:32]};
			end
			hdr_ff[4] <= {tpfg_pkg::RST_ETYPE, tpfg_pkg::RST_OPCODE_GP};
			hdr_ff[9] <= {tpfg_pkg::RST_ETYPE, tpfg_pkg::RST_OPCODE_PP};
		end else if (wr) begin
			for (int k = 0; k < 2 * tpfg_pkg::HDR_WORDS; k++) begin
				if (wadr == 10'((tpfg_pkg::ADR_HDR >> 2) + k)) begin
					hdr_ff[k] <= merge(hdr_ff[k], WB_DAT_I,
						(k % tpfg_pkg::HDR_WORDS == 1 || k % tpfg_pkg::HDR_WORDS == 3) ?
						(WB_SEL_I & 4'h3) : WB_SEL_I);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status, read clears only the bits that were returned; new events win

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			status_ff <= 9'h000;
		end else if (ack_ff && wb_req && !WB_WE_I && wadr == tpfg_pkg::ADR_STATUS[11:2]) begin
			status_ff <= (status_ff & ~dat_ff[8:0]) | sent_ff;
		end else begin
			status_ff <= status_ff | sent_ff;
		end
	end

	assign IRQ = |(status_ff & mask_ff);

	////////////////////////////////////////////////////////////////////////////
	// quantum tick divider and per-class timers

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tick_cnt_ff <= 4'h0;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= (tick_cnt_ff == tpfg_pkg::TICK_LAST);
			tick_cnt_ff <= (tick_cnt_ff == tpfg_pkg::TICK_LAST) ? 4'h0 : tick_cnt_ff + 4'h1;
		end
	end

	generate
		for (genvar g = 0; g < tpfg_pkg::NCLS; g++) begin : g_cls
			tpfg_class_timer u_tmr (
				.clk     (CLK),
				.nrst    (NRST),
				.tick    (tick_ff),
				.req     (req_ff[g]),
				.take    (take[g]),
				.resend  (resend_ff),
				.refresh (refresh_ff[g]),
				.due     (due[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// frame scheduler; global first, all due priorities share one frame

	assign sel_glob = due[tpfg_pkg::GLOBAL_IDX];
	assign sel_vec  = sel_glob ? 8'h00 : due[7:0];
	assign start    = (state_ff == tpfg_pkg::TPFG_IDLE) & (|due) & ~LINK_BUSY;
	assign take     = start ? (sel_glob ? 9'h100 : {1'b0, sel_vec}) : 9'h000;
	assign beat     = (state_ff == tpfg_pkg::TPFG_SEND) & TX_READY;
	assign nxt_idx  = idx_ff + 6'h01;
	assign TX_VALID = (state_ff == tpfg_pkg::TPFG_SEND);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= tpfg_pkg::TPFG_IDLE;
		end else begin
			unique case (state_ff)
				tpfg_pkg::TPFG_IDLE: begin
					if (start) begin
						state_ff <= tpfg_pkg::TPFG_SEND;
					end
				end
				tpfg_pkg::TPFG_SEND: begin
					if (beat && idx_ff == tpfg_pkg::LAST_IDX) begin
						state_ff <= tpfg_pkg::TPFG_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte path: header, class fields, zero pad, then fcs low byte first

	tpfg_crc32 u_crc (
		.clk     (CLK),
		.nrst    (NRST),
		.init    (start),
		.en      (beat && idx_ff < tpfg_pkg::FCS_IDX),
		.data    (byte_ff),
		.nxt_crc (nxt_crc)
	);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			idx_ff  <= 6'h00;
			glob_ff <= 1'b0;
			vec_ff  <= 8'h00;
			byte_ff <= 8'h00;
			sof_ff  <= 1'b0;
			eof_ff  <= 1'b0;
			fcs_ff  <= 32'h00000000;
		end else if (start) begin
			idx_ff  <= 6'h00;
			glob_ff <= sel_glob;
			vec_ff  <= sel_vec;
			byte_ff <= frame_byte(6'h00, sel_glob, sel_vec);
			sof_ff  <= 1'b1;
			eof_ff  <= 1'b0;
		end else if (beat && idx_ff != tpfg_pkg::LAST_IDX) begin
			idx_ff <= nxt_idx;
			sof_ff <= 1'b0;
			eof_ff <= (nxt_idx == tpfg_pkg::LAST_IDX);
			if (nxt_idx == tpfg_pkg::FCS_IDX) begin
				fcs_ff  <= ~nxt_crc;
				byte_ff <= ~nxt_crc[7:0];
			end else if (nxt_idx > tpfg_pkg::FCS_IDX) begin
				byte_ff <= 8'(fcs_ff >> (8 * int'(nxt_idx - tpfg_pkg::FCS_IDX)));
			end else begin
				byte_ff <= frame_byte(nxt_idx, glob_ff, vec_ff);
			end
		end
	end

	assign TX_DATA = byte_ff;
	assign TX_SOF  = sof_ff;
	assign TX_EOF  = eof_ff;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sent_ff <= 9'h000;
		end else if (beat && idx_ff == tpfg_pkg::LAST_IDX) begin
			sent_ff <= glob_ff ? 9'h100 : {1'b0, vec_ff};
		end else begin
			sent_ff <= 9'h000;
		end
	end

	assign TX_PAUSE_VALID = sent_ff;

endmodule

/* tb/tpfg_monitor.sv */
// port assertions for the transmit pause frame generator
`timescale 1ns/1ps
module tpfg_monitor (
	input wire logic       CLK,
	input wire logic       NRST,
	input wire logic       WB_CYC_I,
	input wire logic       WB_STB_I,
	input wire logic       WB_ACK_O,
	input wire logic       LINK_BUSY,
	input wire logic       TX_READY,
	input wire logic       TX_VALID,
	input wire logic [7:0] TX_DATA,
	input wire logic       TX_SOF,
	input wire logic       TX_EOF,
	input wire logic [8:0] TX_PAUSE_VALID
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	////////////////////////////////////////////////////////////////
	logic [6:0] nbyte_ff;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			nbyte_ff <= 7'h00;
		else if (TX_VALID && TX_READY)
			nbyte_ff <= TX_EOF ? 7'h00 : nbyte_ff + 7'h01;
	end
	sequence s_beat_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence s_last_beat;
		TX_VALID && TX_EOF && TX_READY;
	endsequence
	////////////////////////////////////////////////////////////////
	wb_ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing after request");
	wb_ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	wb_ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	byte_hold_a: assert property (s_beat_stall |=> TX_VALID && $stable(TX_DATA))
		else $error("byte changed while stalled");
	frame_start_a: assert property ($rose(TX_VALID) |-> TX_SOF && !$past(LINK_BUSY))
		else $error("bad frame start");
	frame_len_a: assert property (s_last_beat |-> nbyte_ff == 7'h3f)
		else $error("frame not 64 bytes");
	sent_flag_a: assert property (s_last_beat |=> !TX_VALID && TX_PAUSE_VALID != 9'h000)
		else $error("sent flag missing");
	sent_pulse_a: assert property (TX_PAUSE_VALID != 9'h000 |=> TX_PAUSE_VALID == 9'h000)
		else $error("sent flag not a pulse");
	sent_cause_a: assert property (TX_PAUSE_VALID != 9'h000 |-> $past(TX_EOF && TX_READY))
		else $error("sent flag without frame end");
endmodule
bind tpfg_top tpfg_monitor u_mon (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .LINK_BUSY(LINK_BUSY),
	.TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_SOF(TX_SOF),
	.TX_EOF(TX_EOF), .TX_PAUSE_VALID(TX_PAUSE_VALID));

/* tb/tpfg_sink_model.sv */
// transmit sink that stalls and holds the link busy at times
`timescale 1ns/1ps
module tpfg_sink_model (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       valid,
	input  wire logic [7:0] data,
	input  wire logic       eof,
	input  wire logic [8:0] pv,
	output logic            ready,
	output logic            link_busy
);
	logic [7:0] cnt_ff;
	logic [7:0] fbuf [64];
	logic [5:0] idx_ff = 6'h00;
	logic [8:0] last_pv = 9'h000;
	int         nfr = 0;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_ff <= 8'h00;
		else
			cnt_ff <= cnt_ff + 8'h01;
	end
	// one stall in eight, busy link one eighth of the time
	assign ready = cnt_ff[2:0] != 3'h5;
	assign link_busy = cnt_ff[7:5] == 3'h7;
	always @(posedge clk) begin
		if (valid && ready) begin
			fbuf[idx_ff] <= data;
			idx_ff <= eof ? 6'h00 : idx_ff + 6'h01;
			nfr <= nfr + (eof ? 1 : 0);
		end
		if (pv != 9'h000)
			last_pv <= pv;
	end
endmodule

/* tb/test_tx_pause_frame_generator.sv */
// register driven testbench of the transmit pause frame generator
`timescale 1ns/1ps
module test_tx_pause_frame_generator;
	logic        CLK = 1'b0;
	logic        NRST = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wd = 32'h00000000;
	logic [31:0] q;
	wire  [31:0] rd;
	wire         ack, rdy, busy, vld, sof, eof, irq;
	wire  [7:0]  dat;
	wire  [8:0]  pv;
	int          n_fail = 0;
	int          compares = 0;
	int          n;
	tpfg_top dut (.CLK(CLK), .NRST(NRST), .WB_CYC_I(stb), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
		.LINK_BUSY(busy), .TX_READY(rdy), .TX_VALID(vld), .TX_DATA(dat), .TX_SOF(sof),
		.TX_EOF(eof), .TX_PAUSE_VALID(pv), .IRQ(irq));
	tpfg_sink_model m (.clk(CLK), .nrst(NRST), .valid(vld), .data(dat), .eof(eof),
		.pv(pv), .ready(rdy), .link_busy(busy));
	initial begin
		forever #5 CLK = ~CLK;
	end
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (ack !== 1'b1 && i < 50);
		q = rd;
		stb <= 1'b0;
		@(posedge CLK);
		if (i >= 50) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		wr(1'b0, a, 32'h00000000);
		chk(q[15:0], e);
	endtask
	task automatic wait_fr(input int k);
		int i;
		for (i = 0; i < 3000 && m.nfr < k; i++)
			@(posedge CLK);
		repeat (2) @(posedge CLK);
		if (i >= 3000) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	function automatic logic [15:0] fw(input int k);
		return {m.fbuf[k], m.fbuf[k + 1]};
	endfunction
	// reference ethernet crc over the captured bytes ahead of the fcs
	function automatic logic [31:0] fcs_calc();
		logic [31:0] c;
		c = tpfg_pkg::CRC_INIT;
		for (int k = 0; k < int'(tpfg_pkg::FCS_IDX); k++) begin
			for (int i = 0; i < 8; i++) begin
				c = (c[0] ^ m.fbuf[k][i]) ? ((c >> 1) ^ tpfg_pkg::CRC_POLY) : (c >> 1);
			end
		end
		return ~c;
	endfunction
	task automatic chk_frm(input logic [15:0] op, input logic [8:0] cls);
		logic [31:0] f;
		f = fcs_calc();
		chk({m.fbuf[61], m.fbuf[60]}, f[15:0]);
		chk({m.fbuf[63], m.fbuf[62]}, f[31:16]);
		chk(fw(0), tpfg_pkg::RST_DA[47:32]);
		chk(fw(4), tpfg_pkg::RST_DA[15:0]);
		chk(fw(12), tpfg_pkg::RST_ETYPE);
		chk(fw(14), op);
		chk(fw(58), 16'h0000);
		chk({7'h00, m.last_pv}, {7'h00, cls});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		rdc(tpfg_pkg::ADR_QUANTA, 16'hffff);
		rdc(tpfg_pkg::ADR_REFRESH, 16'h0000);
		rdc(tpfg_pkg::ADR_MASK, 16'h0000);
		rdc(12'hffc, 16'h0000);
		wr(1'b1, tpfg_pkg::ADR_MASK, 32'h000001ff);
		wr(1'b1, 12'h060, 32'h00001234);
		wr(1'b1, 12'h0c8, 32'ha1b2c3d4);
		wr(1'b1, tpfg_pkg::ADR_CTRL, 32'h00000100);
		wait_fr(1);
		chk_frm(tpfg_pkg::RST_OPCODE_GP, 9'h100);
		chk(fw(16), 16'h1234);
		chk(fw(8), 16'ha1b2);
		chk({15'h0000, irq}, 16'h0001);
		rdc(tpfg_pkg::ADR_STATUS, 16'h0100);
		rdc(tpfg_pkg::ADR_STATUS, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wr(1'b1, tpfg_pkg::ADR_CTRL, 32'h00010100);
		wait_fr(2);
		chk_frm(tpfg_pkg::RST_OPCODE_GP, 9'h100);
		rdc(tpfg_pkg::ADR_CTRL, 16'h0100);
		wr(1'b1, 12'h040, 32'h00001111);
		wr(1'b1, 12'h048, 32'h00002222);
		wr(1'b1, 12'h0dc, 32'h55667788);
		wr(1'b1, tpfg_pkg::ADR_CTRL, 32'h00000005);
		wait_fr(3);
		chk_frm(tpfg_pkg::RST_OPCODE_PP, 9'h005);
		chk(fw(8), 16'h5566);
		chk(fw(10), 16'h7788);
		chk(fw(16), 16'h0005);
		chk(fw(18), 16'h1111);
		chk(fw(20), 16'h0000);
		chk(fw(22), 16'h2222);
		wr(1'b1, 12'h080, 32'h00000003);
		wr(1'b1, tpfg_pkg::ADR_CTRL, 32'h00010005);
		wait_fr(6);
		chk({7'h00, m.last_pv}, 16'h0001);
		wr(1'b1, tpfg_pkg::ADR_CTRL, 32'h00000000);
		n = m.nfr;
		repeat (400) @(posedge CLK);
		chk(16'(m.nfr > n + 1), 16'h0000);
		rdc(tpfg_pkg::ADR_STATE, 16'h0000);
		tally_and_finish();
	end
endmodule
